// ==== core/morf_pkg.sv ====
/*
 * morf_pkg: constants, field layouts and carrier types of the operation
 * register file. Assumes one 40 MHz core clock and an active low
 * asynchronous power-on reset.
 */
package morf_pkg;
    localparam logic [5:0] ADR_INDIRECT = 6'h00;
    localparam logic [5:0] ADR_TICK = 6'h01;
    localparam logic [5:0] ADR_PC_LOW = 6'h02;
    localparam logic [5:0] ADR_STATUS = 6'h03;
    localparam logic [5:0] ADR_POINTER = 6'h04;
    localparam logic [5:0] ADR_PORT5 = 6'h05;
    localparam logic [5:0] ADR_PORT9 = 6'h09;
    localparam logic [5:0] ADR_EEPROM = 6'h0A;
    localparam logic [5:0] ADR_PATTERN = 6'h0B;
    localparam logic [5:0] ADR_USB = 6'h0C;
    localparam logic [5:0] ADR_FIFO_ADR = 6'h0D;
    localparam logic [5:0] ADR_FIFO_DAT = 6'h0E;
    localparam logic [5:0] ADR_RAM_LO = 6'h10;
    localparam logic [5:0] ADR_BANKED = 6'h20;
    localparam int RAM_COMMON = 16;
    localparam int RAM_BANK = 32;
    localparam int RAM_WORDS = 144;
    localparam int FIFO_WORDS = 32;
    localparam int NUM_PORTS = 5;
    localparam logic [7:0] EEPROM_RST = 8'h03;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [7:0] STATUS_RST = 8'h18;
    // status bit positions
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_P = 3;
    localparam int ST_T = 4;
    localparam int ST_PS = 5;
    // usb status bit positions
    localparam int US_STALL = 0;
    localparam int US_BUSY = 1;
    localparam int US_SUSP = 2;
    localparam int US_EP2_RX = 3;
    localparam int US_TX0 = 4;
    localparam int US_EP0_RX = 7;
    localparam int PTR_BANK = 6;
    localparam int FIFO_AW = 5;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SUSPEND_IDLE_NS = 3_000_000;
    localparam int SUSPEND_CYCLES =
        (SUSPEND_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic rd;
        logic wr;
        logic io_rd;
        logic io_wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } morf_req_t;

    typedef struct packed {
        logic we;
        logic c;
        logic dc;
        logic z;
    } morf_alu_t;

    typedef struct packed {
        logic setup_ok;
        logic ep_zero_fifo_busy;
        logic bus_active;
        logic ep0_rx_done;
        logic ep2_rx_done;
        logic [2:0] tx_done;
    } morf_usb_ev_t;
endpackage : morf_pkg

// ==== core/morf_regfile.sv ====
/*
 * morf_regfile: operation register file of the core: indirect port,
 * tick counter, program counter, status, ram pointer, port data, usb
 * flags, fifo window and banked ram. Assumes the cpu issues one request
 * per cycle and reads answer one cycle later.
 */
`timescale 1ns/1ps
module morf_regfile #(
    parameter int IDLE_CYCLES = morf_pkg::SUSPEND_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire morf_pkg::morf_req_t req_i,
    input wire morf_pkg::morf_alu_t alu_i,
    input wire logic pc_inc_i,
    input wire logic pc_load_i,
    input wire logic [12:0] pc_target_i,
    input wire logic tick_en_i,
    input wire logic wdt_rst_i,
    input wire logic watchdog_clear_instruction_i,
    input wire logic sleep_i,
    input wire logic [39:0] port_pins_i,
    input wire morf_pkg::morf_usb_ev_t usb_ev_i,
    input wire logic udc_fifo_we_i,
    input wire logic [4:0] udc_fifo_addr_i,
    input wire logic [7:0] udc_fifo_wdata_i,
    output logic [7:0] rdata_o,
    output logic [12:0] pc_o,
    output logic [7:0] status_o,
    output logic [39:0] port_data_o,
    output logic [39:0] port_dir_o,
    output logic [7:0] usb_flags_o,
    output logic ep2_nak_o,
    output logic ep0_rx_block_o,
    output logic [7:0] udc_fifo_rdata_o
);
    import morf_pkg::*;

    logic [7:0] tick_q, tick_d;
    logic [12:0] pc_q, pc_d;
    logic [7:0] ptr_q, ptr_d;
    logic [7:0] port_q [NUM_PORTS];
    logic [7:0] port_d [NUM_PORTS];
    logic [7:0] dir_q [NUM_PORTS];
    logic [7:0] dir_d [NUM_PORTS];
    logic [7:0] eep_q, eep_d;
    logic [7:0] pat_q, pat_d;
    logic [4:0] fad_q, fad_d;
    logic [7:0] rd_q, rd_d;
    logic [7:0] ufr_q;
    logic [7:0] status_w, flags_w;
    logic [7:0] ram [RAM_WORDS];
    logic [7:0] fifo [FIFO_WORDS];
    logic [5:0] eff_addr;
    logic [1:0] eff_bank;
    logic ram_hit, st_wr, usb_wr, fifo_wr;
    logic [7:0] pin_sel, dir_sel;

    // address zero redirects through the pointer register
    always_comb begin
        if (req_i.addr == ADR_INDIRECT) begin
            eff_addr = ptr_q[5:0];
            eff_bank = ptr_q[7:PTR_BANK];
        end else begin
            eff_addr = req_i.addr;
            eff_bank = ptr_q[7:PTR_BANK];
        end
    end

    // common space ignores the bank bits
    function automatic logic [7:0] ram_index(input logic [5:0] a,
                                             input logic [1:0] b);
        logic [7:0] idx;
        idx = 8'h00;
        if (a < ADR_BANKED) begin
            idx = {2'b00, a - ADR_RAM_LO};
        end else begin
            idx = 8'(RAM_COMMON) + {1'b0, b, 5'h00} +
                  {2'b00, a - ADR_BANKED};
        end
        return idx;
    endfunction : ram_index

    function automatic logic is_port(input logic [5:0] a);
        return (a >= ADR_PORT5) && (a <= ADR_PORT9);
    endfunction : is_port

    // port registers sit back to back from the first port address
    function automatic logic [2:0] port_index(input logic [5:0] a);
        logic [5:0] off;
        off = a - ADR_PORT5;
        return off[2:0];
    endfunction : port_index

    assign ram_hit = eff_addr >= ADR_RAM_LO;
    assign st_wr = req_i.wr && eff_addr == ADR_STATUS;
    assign usb_wr = req_i.wr && eff_addr == ADR_USB;
    assign fifo_wr = req_i.wr && eff_addr == ADR_FIFO_DAT;

    morf_status u_status (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .wr_i(st_wr),
        .wdata_i(req_i.wdata),
        .alu_i(alu_i),
        .wdt_rst_i(wdt_rst_i),
        .watchdog_clear_instruction_i(watchdog_clear_instruction_i),
        .sleep_i(sleep_i),
        .status_o(status_w)
    );

    morf_usb_flags #(
        .IDLE_CYCLES(IDLE_CYCLES)
    ) u_usb (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .wr_i(usb_wr),
        .wdata_i(req_i.wdata),
        .ev_i(usb_ev_i),
        .flags_o(flags_w)
    );

    // counters: tick and program counter
    always_comb begin
        tick_d = tick_q;
        pc_d = pc_q;
        if (tick_en_i) begin
            tick_d = tick_q + 8'h01;
        end
        if (pc_load_i) begin
            pc_d = pc_target_i;
        end else if (pc_inc_i) begin
            pc_d = pc_q + 13'h0001;
        end
        if (req_i.wr && eff_addr == ADR_TICK) begin
            tick_d = req_i.wdata;
        end
        // a jump through the low byte takes its page bits
        if (req_i.wr && eff_addr == ADR_PC_LOW) begin
            pc_d = {status_w[7:ST_PS], 2'b00, req_i.wdata};
        end
        // watchdog reset beats every other source
        if (wdt_rst_i) begin
            tick_d = ZERO_BYTE;
            pc_d = '0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_q <= ZERO_BYTE;
            pc_q <= '0;
        end else begin
            tick_q <= tick_d;
            pc_q <= pc_d;
        end
    end

    // pointer, port latches, directions and plain control bytes
    always_comb begin
        ptr_d = ptr_q;
        port_d = port_q;
        dir_d = dir_q;
        eep_d = eep_q;
        pat_d = pat_q;
        fad_d = fad_q;
        if (req_i.wr) begin
            unique case (eff_addr)
                ADR_POINTER: ptr_d = req_i.wdata;
                ADR_EEPROM: eep_d = req_i.wdata;
                ADR_PATTERN: pat_d = req_i.wdata;
                ADR_FIFO_ADR: fad_d = req_i.wdata[FIFO_AW-1:0];
                default: begin
                    if (is_port(eff_addr)) begin
                        port_d[port_index(eff_addr)] = req_i.wdata;
                    end
                end
            endcase
        end
        // direction registers never answer ordinary data accesses
        if (req_i.io_wr && is_port(req_i.addr)) begin
            dir_d[port_index(req_i.addr)] = req_i.wdata;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr_q <= ZERO_BYTE;
            for (int i = 0; i < NUM_PORTS; i++) begin
                port_q[i] <= ZERO_BYTE;
                dir_q[i] <= DIR_RST;
            end
            eep_q <= EEPROM_RST;
            pat_q <= ZERO_BYTE;
            fad_q <= 5'h00;
        end else begin
            ptr_q <= ptr_d;
            port_q <= port_d;
            dir_q <= dir_d;
            eep_q <= eep_d;
            pat_q <= pat_d;
            fad_q <= fad_d;
        end
    end

    // read data, one cycle after the request
    always_comb begin
        rd_d = rd_q;
        pin_sel = ZERO_BYTE;
        dir_sel = ZERO_BYTE;
        if (req_i.io_rd) begin
            rd_d = is_port(req_i.addr) ?
                   dir_q[port_index(req_i.addr)] : ZERO_BYTE;
        end else if (req_i.rd) begin
            rd_d = ZERO_BYTE;
            if (ram_hit) begin
                rd_d = ram[ram_index(eff_addr, eff_bank)];
            end else if (is_port(eff_addr)) begin
                // input bits show the pin, output bits the latch
                pin_sel = port_pins_i[8*port_index(eff_addr) +: 8];
                dir_sel = dir_q[port_index(eff_addr)];
                rd_d = (pin_sel & dir_sel) |
                       (port_q[port_index(eff_addr)] & ~dir_sel);
            end else begin
                unique case (eff_addr)
                    ADR_TICK: rd_d = tick_q;
                    ADR_PC_LOW: rd_d = pc_q[7:0];
                    ADR_STATUS: rd_d = status_w;
                    ADR_POINTER: rd_d = ptr_q;
                    ADR_EEPROM: rd_d = eep_q;
                    ADR_PATTERN: rd_d = pat_q;
                    ADR_USB: rd_d = flags_w;
                    ADR_FIFO_ADR: rd_d = {3'b000, fad_q};
                    ADR_FIFO_DAT: rd_d = fifo[fad_q];
                    default: rd_d = ZERO_BYTE;
                endcase
            end
        end
    end

    // read side: cpu read data and the controller's fifo read port
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_q <= ZERO_BYTE;
            ufr_q <= ZERO_BYTE;
        end else begin
            rd_q <= rd_d;
            ufr_q <= fifo[udc_fifo_addr_i];
        end
    end

    // storage arrays carry no reset; contents are undefined at power-on
    always_ff @(posedge sys_clk_i) begin
        if (req_i.wr && ram_hit) begin
            ram[ram_index(eff_addr, eff_bank)] <= req_i.wdata;
        end
        // controller writes win; firmware stays off while busy
        if (udc_fifo_we_i) begin
            fifo[udc_fifo_addr_i] <= udc_fifo_wdata_i;
        end else if (fifo_wr) begin
            fifo[fad_q] <= req_i.wdata;
        end
    end

    assign rdata_o = rd_q;
    assign pc_o = pc_q;
    assign status_o = status_w;
    assign usb_flags_o = flags_w;
    assign ep2_nak_o = flags_w[US_EP2_RX];
    assign ep0_rx_block_o = flags_w[US_EP0_RX];
    assign udc_fifo_rdata_o = ufr_q;
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            port_data_o[8*i +: 8] = port_q[i];
            port_dir_o[8*i +: 8] = dir_q[i];
        end
    end
endmodule : morf_regfile

// ==== core/morf_status.sv ====
/*
 * morf_status: the core status byte with flags, power and page fields.
 * Assumes event inputs are one-cycle pulses on the core clock.
 */
`timescale 1ns/1ps
module morf_status (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire morf_pkg::morf_alu_t alu_i,
    input wire logic wdt_rst_i,
    input wire logic watchdog_clear_instruction_i,
    input wire logic sleep_i,
    output logic [7:0] status_o
);
    import morf_pkg::*;
    logic [7:0] st_q, st_d;

    always_comb begin
        st_d = st_q;
        if (alu_i.we) begin
            st_d[ST_C] = alu_i.c;
            st_d[ST_DC] = alu_i.dc;
            st_d[ST_Z] = alu_i.z;
        end
        // power and time-out bits are not writable by software
        if (wr_i) begin
            st_d[ST_Z:ST_C] = wdata_i[ST_Z:ST_C];
            st_d[7:ST_PS] = wdata_i[7:ST_PS];
        end
        if (sleep_i) begin
            st_d[ST_P] = 1'b0;
            st_d[ST_T] = 1'b1;
        end
        if (watchdog_clear_instruction_i) begin
            st_d[ST_P] = 1'b1;
            st_d[ST_T] = 1'b1;
        end
        if (wdt_rst_i) begin
            st_d[ST_T] = 1'b0;
            st_d[7:ST_PS] = '0;
        end
    end

    // wakeup touches nothing, so sleep's T=1 P=0 survives it
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= STATUS_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign status_o = st_q;
endmodule : morf_status

// ==== core/morf_usb_flags.sv ====
/*
 * morf_usb_flags: usb application status byte shared between firmware
 * and the usb device controller. Assumes controller events are pulses.
 */
`timescale 1ns/1ps
module morf_usb_flags #(
    parameter int IDLE_CYCLES = morf_pkg::SUSPEND_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire morf_pkg::morf_usb_ev_t ev_i,
    output logic [7:0] flags_o
);
    import morf_pkg::*;
    logic [7:0] fl_q, fl_d;
    logic [16:0] idle_q, idle_d;

    always_comb begin
        fl_d = fl_q;
        idle_d = idle_q;
        if (wr_i) begin
            fl_d[US_STALL] = wdata_i[US_STALL];
            fl_d[US_EP2_RX] = wdata_i[US_EP2_RX];
            fl_d[US_EP0_RX] = wdata_i[US_EP0_RX];
        end
        if (ev_i.setup_ok) begin
            fl_d[US_STALL] = 1'b0;
        end
        // hardware set wins over a firmware clear in the same cycle
        if (ev_i.ep2_rx_done) begin
            fl_d[US_EP2_RX] = 1'b1;
        end
        if (ev_i.ep0_rx_done) begin
            fl_d[US_EP0_RX] = 1'b1;
        end
        for (int i = 0; i < 3; i++) begin
            if (ev_i.tx_done[i]) begin
                fl_d[US_TX0 + i] = 1'b0;
            end
            // writing zero leaves a request alone; only firmware sets
            if (wr_i && wdata_i[US_TX0 + i]) begin
                fl_d[US_TX0 + i] = 1'b1;
            end
        end
        fl_d[US_BUSY] = ev_i.ep_zero_fifo_busy;
        if (ev_i.bus_active) begin
            idle_d = '0;
            fl_d[US_SUSP] = 1'b0;
        end else if (idle_q == 17'(IDLE_CYCLES - 1)) begin
            fl_d[US_SUSP] = 1'b1;
        end else begin
            idle_d = idle_q + 17'h0_0001;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fl_q <= 8'h00;
            idle_q <= 17'h0_0000;
        end else begin
            fl_q <= fl_d;
            idle_q <= idle_d;
        end
    end

    assign flags_o = fl_q;
endmodule : morf_usb_flags

// ==== sim/morf_regfile_monitor.sv ====
/*
 * morf_regfile_monitor: port assertions for the register file.
 * Assumes one core clock, async active low reset, bound to morf_regfile.
 */
`timescale 1ns/1ps
module morf_regfile_monitor #(
    parameter int IDLE_CYCLES = morf_pkg::SUSPEND_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire morf_pkg::morf_req_t req_i,
    input wire morf_pkg::morf_alu_t alu_i,
    input wire logic wdt_rst_i,
    input wire logic watchdog_clear_instruction_i,
    input wire logic sleep_i,
    input wire morf_pkg::morf_usb_ev_t usb_ev_i,
    input wire logic [12:0] pc_o,
    input wire logic [7:0] status_o,
    input wire logic [7:0] usb_flags_o,
    input wire logic ep2_nak_o
);
    import morf_pkg::*;
    int idle_q;
    int idle_d;
    // saturates so a long idle spell never wraps
    always_comb begin
        if (usb_ev_i.bus_active)
            idle_d = 0;
        else if (idle_q < IDLE_CYCLES + 4)
            idle_d = idle_q + 1;
        else
            idle_d = idle_q;
    end
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            idle_q <= 0;
        else
            idle_q <= idle_d;
    end
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    stall_clear_a: assert property (
        usb_ev_i.setup_ok |=> !usb_flags_o[US_STALL])
        else $error("stall bit kept after setup");
    ep2_rx_set_a: assert property (
        usb_ev_i.ep2_rx_done |=> usb_flags_o[US_EP2_RX])
        else $error("ep2 receive bit not set");
    ep2_nak_a: assert property (
        ep2_nak_o && !req_i.wr |=> ep2_nak_o)
        else $error("nak dropped before firmware cleared it");
    busy_follow_a: assert property (
        usb_flags_o[US_BUSY] == $past(usb_ev_i.ep_zero_fifo_busy))
        else $error("busy bit does not follow fifo use");
    wdt_reset_a: assert property (
        wdt_rst_i |=> pc_o == 13'h0000 && !status_o[ST_T]
            && status_o[ST_P] == $past(status_o[ST_P]))
        else $error("watchdog reset effect wrong");
    sleep_flags_a: assert property (
        sleep_i && !wdt_rst_i && !watchdog_clear_instruction_i |=> status_o[4:3] == 2'b10)
        else $error("power down flags wrong");
    watchdog_clear_instruction_flags_a: assert property (
        watchdog_clear_instruction_i && !wdt_rst_i && !sleep_i |=> status_o[4:3] == 2'b11)
        else $error("clear instruction flags wrong");
    alu_flags_a: assert property (
        alu_i.we && !req_i.wr && !wdt_rst_i |=> status_o[2:0] ==
            {$past(alu_i.z), $past(alu_i.dc), $past(alu_i.c)})
        else $error("arithmetic flags not loaded");
    tx_clear_a: assert property (
        usb_ev_i.tx_done[0] && !req_i.wr |=> !usb_flags_o[US_TX0])
        else $error("transmit request not cleared");
    susp_early_a: assert property (
        usb_flags_o[US_SUSP] |-> idle_q >= IDLE_CYCLES - 2)
        else $error("suspend set too early");
    susp_late_a: assert property (
        idle_q >= IDLE_CYCLES + 2 |-> usb_flags_o[US_SUSP])
        else $error("suspend not set after idle");
    cover property (usb_ev_i.setup_ok && usb_flags_o[US_STALL]);
    cover property ($rose(usb_flags_o[US_SUSP]));
    cover property (wdt_rst_i && status_o[ST_P]);
endmodule : morf_regfile_monitor

bind morf_regfile morf_regfile_monitor #(
    .IDLE_CYCLES(IDLE_CYCLES)
) morf_regfile_monitor_i (
    .sys_clk_i,
    .rst_n_i,
    .req_i,
    .alu_i,
    .wdt_rst_i,
    .watchdog_clear_instruction_i,
    .sleep_i,
    .usb_ev_i,
    .pc_o,
    .status_o,
    .usb_flags_o,
    .ep2_nak_o
);

// ==== sim/morf_regfile_tb.sv ====
/*
 * morf_regfile_tb: self-checking bench of the register file.
 * Assumes the controller model beside it; short suspend count.
 */
`timescale 1ns/1ps
module morf_regfile_tb;
    import morf_pkg::*;
    localparam int IDLE = 200;
    logic sys_clk;
    logic rst_n;
    morf_req_t req;
    morf_alu_t alu;
    logic pc_inc, pc_load, tick_en, wdt, watchdog_clear_instruction, sleep;
    logic [12:0] pc_target, pc;
    logic [39:0] pins, port_data, port_dir;
    morf_usb_ev_t ev;
    logic f_we, ep2_nak, ep0_blk;
    logic [4:0] f_addr;
    logic [7:0] f_wdata, f_rdata, rdata, status, usb_flags;
    int total_checks = 0;
    int miscompares = 0;
    morf_regfile #(.IDLE_CYCLES(IDLE)) morf_regfile_i (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .req_i(req), .alu_i(alu),
        .pc_inc_i(pc_inc), .pc_load_i(pc_load), .pc_target_i(pc_target),
        .tick_en_i(tick_en), .wdt_rst_i(wdt), .watchdog_clear_instruction_i(watchdog_clear_instruction),
        .sleep_i(sleep), .port_pins_i(pins), .usb_ev_i(ev),
        .udc_fifo_we_i(f_we), .udc_fifo_addr_i(f_addr),
        .udc_fifo_wdata_i(f_wdata), .rdata_o(rdata), .pc_o(pc),
        .status_o(status), .port_data_o(port_data), .port_dir_o(port_dir),
        .usb_flags_o(usb_flags), .ep2_nak_o(ep2_nak),
        .ep0_rx_block_o(ep0_blk), .udc_fifo_rdata_o(f_rdata));
    morf_udc_model morf_udc_model_i (
        .sys_clk_i(sys_clk), .ep2_nak_i(ep2_nak), .ep0_rx_block_i(ep0_blk),
        .ev_o(ev), .fifo_we_o(f_we), .fifo_addr_o(f_addr),
        .fifo_wdata_o(f_wdata));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic io, input logic w, input logic [5:0] a,
                       input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        req = '{rd: ~io & ~w, wr: ~io & w, io_rd: io & ~w, io_wr: io & w,
                addr: a, wdata: d};
        @(posedge sys_clk);
        #1;
        req = '{wdata: ~d, default: '0};
        @(posedge sys_clk);
        #1;
    endtask : acc
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        acc(1'b0, 1'b1, a, d);
    endtask : wr
    task automatic rd(input logic io, input logic [5:0] a,
                      input logic [7:0] e);
        acc(io, 1'b0, a, 8'h00);
        chk(16'(rdata), 16'(e));
    endtask : rd
    task automatic pls(ref logic s);
        @(posedge sys_clk);
        #1;
        s = 1'b1;
        @(posedge sys_clk);
        #1;
        s = 1'b0;
    endtask : pls
    task automatic t_reset();
        rd(1'b0, ADR_TICK, ZERO_BYTE);
        rd(1'b0, ADR_PC_LOW, ZERO_BYTE);
        chk(16'(status[4:3]), 16'h0003);
        rd(1'b0, ADR_EEPROM, EEPROM_RST);
        rd(1'b0, ADR_USB, ZERO_BYTE);
        rd(1'b1, ADR_PORT5, DIR_RST);
    endtask : t_reset
    task automatic t_indirect();
        wr(ADR_POINTER, 8'hBC);
        wr(ADR_INDIRECT, 8'h5A);
        wr(ADR_POINTER, 8'hFC);
        wr(ADR_INDIRECT, 8'hA5);
        wr(ADR_POINTER, 8'hBC);
        rd(1'b0, ADR_INDIRECT, 8'h5A);
        wr(ADR_POINTER, 8'h1C);
        wr(ADR_INDIRECT, 8'h33);
        wr(ADR_POINTER, 8'hDC);
        rd(1'b0, ADR_INDIRECT, 8'h33);
        rd(1'b0, 6'h1C, 8'h33);
    endtask : t_indirect
    task automatic t_tick();
        wr(ADR_TICK, 8'hFE);
        pls(tick_en);
        pls(tick_en);
        rd(1'b0, ADR_TICK, 8'h00);
        pls(tick_en);
        pls(wdt);
        rd(1'b0, ADR_TICK, 8'h00);
    endtask : t_tick
    task automatic t_status();
        wr(ADR_STATUS, 8'hA0);
        chk(16'(status[7:5]), 16'h0005);
        wr(ADR_PC_LOW, 8'h12);
        chk(16'(pc), 16'h1412);
        pls(pc_inc);
        chk(16'(pc), 16'h1413);
        pls(pc_load);
        rd(1'b0, ADR_PC_LOW, 8'h00);
        @(posedge sys_clk);
        #1;
        alu = '{we: 1'b1, c: 1'b1, dc: 1'b0, z: 1'b1};
        @(posedge sys_clk);
        #1;
        alu = '0;
        chk(16'(status[2:0]), 16'h0005);
        pls(sleep);
        chk(16'(status[4:3]), 16'h0002);
        pls(wdt);
        chk(16'(status[4:3]), 16'h0000);
        chk(16'(pc), 16'h0000);
        pls(watchdog_clear_instruction);
        chk(16'(status[4:3]), 16'h0003);
        pls(wdt);
        chk(16'(status[4:3]), 16'h0001);
    endtask : t_status
    task automatic t_io();
        acc(1'b1, 1'b1, ADR_PORT5, 8'h0F);
        wr(ADR_PORT5, 8'hA5);
        chk(16'(port_dir[7:0]), 16'h000F);
        chk(16'(port_data[7:0]), 16'h00A5);
        pins[7:0] = 8'h3C;
        rd(1'b0, ADR_PORT5, 8'hAC);
        rd(1'b1, ADR_PORT5, 8'h0F);
        rd(1'b1, ADR_STATUS, 8'h00);
    endtask : t_io
    task automatic t_usb();
        morf_udc_model_i.setup();
        wr(ADR_USB, 8'h11);
        rd(1'b0, ADR_USB, 8'h11);
        morf_udc_model_i.setup();
        rd(1'b0, ADR_USB, 8'h10);
        wr(ADR_USB, 8'h00);
        rd(1'b0, ADR_USB, 8'h10);
        morf_udc_model_i.tx_read(0);
        rd(1'b0, ADR_USB, 8'h00);
        morf_udc_model_i.ep2_out();
        chk(16'(ep2_nak), 16'h0001);
        morf_udc_model_i.ep2_out();
        wr(ADR_USB, 8'h00);
        rd(1'b0, ADR_USB, 8'h00);
        morf_udc_model_i.ep0_in(8'h77);
        chk(16'(ep0_blk), 16'h0001);
        morf_udc_model_i.ep0_in(8'h99);
        chk(16'(morf_udc_model_i.refused), 16'h0002);
        chk(16'(f_rdata), 16'h0077);
        rd(1'b0, ADR_USB, 8'h80);
        wr(ADR_FIFO_ADR, 8'h05);
        wr(ADR_FIFO_DAT, 8'h42);
        wr(ADR_FIFO_ADR, 8'h00);
        rd(1'b0, ADR_FIFO_DAT, 8'h77);
        wr(ADR_FIFO_ADR, 8'h05);
        rd(1'b0, ADR_FIFO_DAT, 8'h42);
    endtask : t_usb
    task automatic t_suspend();
        morf_udc_model_i.setup();
        repeat (IDLE + 4) @(posedge sys_clk);
        #1;
        chk(16'(usb_flags[US_SUSP]), 16'h0001);
        morf_udc_model_i.setup();
        chk(16'(usb_flags[US_SUSP]), 16'h0000);
    endtask : t_suspend
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // about 400 cycles needed; generous margin
    initial begin
        #(25 * 6000);
        miscompares++;
        report_and_stop();
    end
    initial begin
        {req, alu, pc_inc, pc_load, tick_en, wdt, watchdog_clear_instruction, sleep} = '0;
        pc_target = 13'h0400;
        pins = '0;
        rst_n = 1'b0;
        repeat (16) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_indirect();
        t_tick();
        t_status();
        t_io();
        t_usb();
        t_suspend();
        report_and_stop();
    end
endmodule : morf_regfile_tb

// ==== sim/morf_udc_model.sv ====
/*
 * morf_udc_model: behavioural usb device controller facing the flags.
 * Assumes the bench calls one task at a time, core clock only.
 */
`timescale 1ns/1ps
module morf_udc_model (
    input wire logic sys_clk_i,
    input wire logic ep2_nak_i,
    input wire logic ep0_rx_block_i,
    output morf_pkg::morf_usb_ev_t ev_o,
    output logic fifo_we_o,
    output logic [4:0] fifo_addr_o,
    output logic [7:0] fifo_wdata_o
);
    import morf_pkg::*;
    int refused = 0;
    initial begin
        ev_o = '0;
        fifo_we_o = 1'b0;
        fifo_addr_o = 5'h00;
        fifo_wdata_o = 8'h00;
    end
    task automatic step();
        @(posedge sys_clk_i);
        #1;
    endtask : step
    task automatic setup();
        step();
        ev_o = '{setup_ok: 1'b1, bus_active: 1'b1, default: '0};
        step();
        ev_o = '0;
        step();
    endtask : setup
    task automatic ep2_out();
        step();
        if (ep2_nak_i)
            refused++;
        else
            ev_o = '{ep2_rx_done: 1'b1, bus_active: 1'b1, default: '0};
        step();
        ev_o = '0;
        step();
    endtask : ep2_out
    // one-byte write; real controller bursts, enough for the flags
    task automatic ep0_in(input logic [7:0] d);
        step();
        if (ep0_rx_block_i) begin
            refused++;
            return;
        end
        ev_o = '{bus_active: 1'b1, ep_zero_fifo_busy: 1'b1, default: '0};
        fifo_we_o = 1'b1;
        fifo_wdata_o = d;
        step();
        fifo_we_o = 1'b0;
        fifo_wdata_o = ~d;
        ev_o = '{bus_active: 1'b1, ep0_rx_done: 1'b1,
                 default: '0};
        step();
        ev_o = '0;
        step();
    endtask : ep0_in
    task automatic tx_read(input int ep);
        step();
        ev_o = '{bus_active: 1'b1, ep_zero_fifo_busy: (ep == 0),
                 default: '0};
        step();
        ev_o = '{bus_active: 1'b1, tx_done: 3'(1 << ep),
                 default: '0};
        step();
        ev_o = '0;
        step();
    endtask : tx_read
endmodule : morf_udc_model
